// ===== core/rsrc_pkg.sv
// shared constants and carriers for receiver start-up and restart control
package rsrc_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam logic [11:0] RELOCK_EXTRA_US = 12'h03C;
  localparam int STRENGTH_DELAY_SHIFT = 3;
  localparam int BW_ENTRIES = 21;
  localparam logic [4:0] BW_LAST = 5'h14;

  // receiver start-up delay per bandwidth index, in microseconds
  localparam logic [11:0] STARTUP_DELAY_US [BW_ENTRIES] = '{
    12'h91A, 12'h794, 12'h618, 12'h49C, 12'h3D8, 12'h317, 12'h259,
    12'h1F8, 12'h197, 12'h139, 12'h108, 12'h0D7, 12'h0A9, 12'h090,
    12'h077, 12'h061, 12'h054, 12'h047, 12'h055, 12'h04A, 12'h03F};

  // register offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_RXCFG = 8'h01;
  localparam logic [7:0] OFS_LNA = 8'h02;
  localparam logic [7:0] OFS_RECEIVE_BANDWIDTH = 8'h03;
  localparam logic [7:0] OFS_AFCBW = 8'h04;
  localparam logic [7:0] OFS_SYNC = 8'h05;
  localparam logic [7:0] OFS_IPKT = 8'h06;
  localparam logic [7:0] OFS_COLL = 8'h07;
  localparam logic [7:0] OFS_SEQ = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h09;
  localparam logic [7:0] OFS_SMOOTH = 8'h0A;

  // field positions
  localparam int FAMILY_BIT = 7;
  localparam int COLL_EN_BIT = 7;
  localparam int NORELOCK_BIT = 6;
  localparam int RELOCK_BIT = 5;
  localparam int AFC_BIT = 4;
  localparam int AGC_BIT = 3;
  localparam int GAIN_LSB = 5;
  localparam int AUTO_LSB = 6;
  localparam int LAUNCH_BIT = 7;
  localparam int STOP_BIT = 6;

  // codes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_FSTX = 3'h2;
  localparam logic [2:0] MODE_RX = 3'h5;
  localparam logic [2:0] TRIG_NONE = 3'h0;
  localparam logic [2:0] TRIG_STRENGTH = 3'h1;
  localparam logic [2:0] TRIG_PREAMBLE = 3'h6;
  localparam logic [2:0] TRIG_BOTH = 3'h7;
  localparam logic [1:0] AUTO_OFF = 2'h0;
  localparam logic [1:0] AUTO_SAME = 2'h1;
  localparam logic [1:0] AUTO_NEWFREQ = 2'h2;

  typedef struct packed {
    logic spread_family;
    logic [2:0] op_mode;
    logic collision_restart_enable;
    logic restart_no_relock_trigger;
    logic restart_relock_trigger;
    logic auto_freq_correction_enable;
    logic auto_gain_control_enable;
    logic [2:0] correction_trigger_select;
    logic [2:0] amplifier_gain_select;
    logic [4:0] receive_bandwidth;
    logic [4:0] correction_bandwidth;
    logic [1:0] auto_restart_select;
    logic [7:0] inter_packet_wait;
    logic [7:0] collision_strength_threshold;
    logic [1:0] strength_smoothing_option;
  } rsrc_cfg_s;

  localparam rsrc_cfg_s CFG_RST = '{
    spread_family: 1'b0, op_mode: MODE_STANDBY, collision_restart_enable: 1'b0,
    restart_no_relock_trigger: 1'b0, restart_relock_trigger: 1'b0,
    auto_freq_correction_enable: 1'b0, auto_gain_control_enable: 1'b1,
    correction_trigger_select: TRIG_PREAMBLE, amplifier_gain_select: 3'h1,
    receive_bandwidth: 5'h0A, correction_bandwidth: 5'h0C,
    auto_restart_select: AUTO_SAME, inter_packet_wait: 8'h00,
    collision_strength_threshold: 8'h0A, strength_smoothing_option: 2'h2};

  typedef struct packed {
    logic strength_irq;
    logic preamble_found_event;
    logic payload_complete_event;
    logic fifo_empty;
    logic strength_update;
    logic [7:0] strength_value;
    logic [2:0] agc_gain;
  } rsrc_evt_s;

  typedef enum logic [2:0] {
    RX_OFF = 3'h0,
    RX_FETCH = 3'h1,
    RX_LOCK = 3'h2,
    RX_STARTUP = 3'h3,
    RX_SAMPLE = 3'h4,
    RX_READY = 3'h5,
    RX_WAIT_FIFO = 3'h6,
    RX_INTERPKT = 3'h7
  } rsrc_state_e;

endpackage

// ===== core/rsrc_rom.sv
// start-up delay lookup memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module rsrc_rom (
  // clock
  input wire logic clk_sys,
  // lookup
  input wire logic [4:0] addr,
  output logic [11:0] q
);
  logic [11:0] next_q;

  // out-of-range index clamps to the widest bandwidth
  always_comb begin
    if (addr > rsrc_pkg::BW_LAST) begin
      next_q = rsrc_pkg::STARTUP_DELAY_US[rsrc_pkg::BW_LAST];
    end else begin
      next_q = rsrc_pkg::STARTUP_DELAY_US[addr];
    end
  end

  always_ff @(posedge clk_sys) begin
    q <= next_q;
  end
endmodule
`default_nettype wire

// ===== core/rsrc_timer.sv
// microsecond down-counter with its own tick divider
`timescale 1ns/10ps
`default_nettype none
module rsrc_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic load,
  input wire logic [11:0] load_val,
  output logic expired
);
  localparam logic [7:0] DIV_LAST = 8'(rsrc_pkg::TICK_CYCLES - 1);
  logic [7:0] div;
  logic [7:0] next_div;
  logic [11:0] cnt;
  logic [11:0] next_cnt;

  // divider restarts on load so a delay is whole microseconds, no jitter
  always_comb begin
    next_div = div;
    next_cnt = cnt;
    if (load) begin
      next_div = 8'h00;
      next_cnt = load_val;
    end else if (cnt != 12'h000) begin
      next_div = (div == DIV_LAST) ? 8'h00 : div + 8'h01;
      if (div == DIV_LAST) begin
        next_cnt = cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div <= 8'h00;
      cnt <= 12'h000;
    end else begin
      div <= next_div;
      cnt <= next_cnt;
    end
  end

  assign expired = (cnt == 12'h000);
endmodule
`default_nettype wire

// ===== core/rsrc_ctrl.sv
// receiver start-up, restart and sequencer launch control
// Function
// - start-up delay uses receive bandwidth, or correction bandwidth when correction is on
// - start-up delay per bandwidth from the table, e.g. 2.33 ms at 2.6 kHz
// - packets are detected and demodulated only after the start-up delay
// - first strength sample comes one bandwidth and smoothing dependent interval later
// - gain and frequency correction run once per packet after every start or restart
// - trigger code 000 none, 001 strength irq, 110 preamble, 111 either
// - with gain control off, amplifier gain comes from the manual gain bits
// - a restart request is ignored unless the mode is settled
// - auto restart code 00 never restarts the receiver after a packet
// - code 01 waits for an empty fifo, then inter-packet wait, then restarts
// - code 10 adds a synthesizer lock delay before the restart
// - collision enable restarts the receiver on a sudden strength rise
// - the strength rise is compared with a 1 dB per step threshold
// - the sequencer runs only in the FSK/OOK family
// - launch bit in sleep or standby starts the sequencer and keeps that initial mode
// - stop bit forces the sequencer off in any state
// - mode code 101 is receive, synthesizer and receiver both on
`timescale 1ns/10ps
`default_nettype none
module rsrc_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // receive chain
  input wire rsrc_pkg::rsrc_evt_s rx_evt,
  output logic synth_enable,
  output logic receiver_enable,
  output logic receiver_ready,
  output logic strength_sample_valid,
  output logic gain_start,
  output logic freq_start,
  output logic [2:0] lna_gain,
  output logic restart_pulse,
  // sequencer
  output logic sequencer_active
);
  rsrc_pkg::rsrc_cfg_s cfg;
  rsrc_pkg::rsrc_cfg_s next_cfg;
  rsrc_pkg::rsrc_state_e state;
  rsrc_pkg::rsrc_state_e next_state;
  logic seq_init_sleep;
  logic next_seq_init_sleep;
  logic next_sequencer_active;
  logic corr_done;
  logic next_corr_done;
  logic [7:0] baseline;
  logic [7:0] next_baseline;
  logic [7:0] next_reg_rdata;
  logic next_restart;
  logic next_gain_start;
  logic next_freq_start;
  logic tmr_load;
  logic [11:0] tmr_val;
  logic expired;
  logic [11:0] rom_q;
  logic rx_mode;
  logic settled;
  logic user_restart;
  logic trig_hit;
  logic collision;

  function automatic logic is_low_power(input logic [2:0] m);
    is_low_power = (m == rsrc_pkg::MODE_SLEEP) || (m == rsrc_pkg::MODE_STANDBY);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  rsrc_rom rsrc_rom_inst (
    .clk_sys(clk_sys),
    .addr(cfg.auto_freq_correction_enable ? cfg.correction_bandwidth
                                          : cfg.receive_bandwidth),
    .q(rom_q)
  );

  rsrc_timer rsrc_timer_inst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration and sequencer launch
  always_comb begin
    next_cfg = cfg;
    next_sequencer_active = sequencer_active;
    next_seq_init_sleep = seq_init_sleep;
    next_cfg.restart_no_relock_trigger = 1'b0;
    next_cfg.restart_relock_trigger = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        rsrc_pkg::OFS_MODE: begin
          next_cfg.spread_family = reg_wdata[rsrc_pkg::FAMILY_BIT];
          next_cfg.op_mode = reg_wdata[2:0];
        end
        rsrc_pkg::OFS_RXCFG: begin
          next_cfg.collision_restart_enable = reg_wdata[rsrc_pkg::COLL_EN_BIT];
          next_cfg.restart_no_relock_trigger = reg_wdata[rsrc_pkg::NORELOCK_BIT];
          next_cfg.restart_relock_trigger = reg_wdata[rsrc_pkg::RELOCK_BIT];
          next_cfg.auto_freq_correction_enable = reg_wdata[rsrc_pkg::AFC_BIT];
          next_cfg.auto_gain_control_enable = reg_wdata[rsrc_pkg::AGC_BIT];
          next_cfg.correction_trigger_select = reg_wdata[2:0];
        end
        rsrc_pkg::OFS_LNA: next_cfg.amplifier_gain_select = reg_wdata[rsrc_pkg::GAIN_LSB +: 3];
        rsrc_pkg::OFS_RECEIVE_BANDWIDTH: next_cfg.receive_bandwidth = reg_wdata[4:0];
        rsrc_pkg::OFS_AFCBW: next_cfg.correction_bandwidth = reg_wdata[4:0];
        rsrc_pkg::OFS_SYNC: next_cfg.auto_restart_select = reg_wdata[rsrc_pkg::AUTO_LSB +: 2];
        rsrc_pkg::OFS_IPKT: next_cfg.inter_packet_wait = reg_wdata;
        rsrc_pkg::OFS_COLL: next_cfg.collision_strength_threshold = reg_wdata;
        rsrc_pkg::OFS_SMOOTH: next_cfg.strength_smoothing_option = reg_wdata[1:0];
        rsrc_pkg::OFS_SEQ: begin
          if (reg_wdata[rsrc_pkg::STOP_BIT]) begin
            next_sequencer_active = 1'b0;
          end else if (reg_wdata[rsrc_pkg::LAUNCH_BIT] && is_low_power(cfg.op_mode)
                       && !cfg.spread_family) begin
            next_sequencer_active = 1'b1;
            next_seq_init_sleep = (cfg.op_mode == rsrc_pkg::MODE_SLEEP);
          end
        end
        default: ;
      endcase
    end
    if (cfg.spread_family) begin
      next_sequencer_active = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg <= rsrc_pkg::CFG_RST;
      sequencer_active <= 1'b0;
      seq_init_sleep <= 1'b0;
    end else begin
      cfg <= next_cfg;
      sequencer_active <= next_sequencer_active;
      seq_init_sleep <= next_seq_init_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver start-up and restart sequencing
  assign rx_mode = (cfg.op_mode == rsrc_pkg::MODE_RX);
  assign settled = (state == rsrc_pkg::RX_OFF) || (state == rsrc_pkg::RX_SAMPLE)
                   || (state == rsrc_pkg::RX_READY) || (state == rsrc_pkg::RX_WAIT_FIFO);
  assign user_restart = (cfg.restart_no_relock_trigger || cfg.restart_relock_trigger)
                        && settled && rx_mode;
  // a sudden rise is measured against the last sample, not a long average
  assign collision = cfg.collision_restart_enable && rx_evt.strength_update
                     && (rx_evt.strength_value > baseline)
                     && ((rx_evt.strength_value - baseline)
                         > cfg.collision_strength_threshold);

  always_comb begin
    case (cfg.correction_trigger_select)
      rsrc_pkg::TRIG_STRENGTH: trig_hit = rx_evt.strength_irq;
      rsrc_pkg::TRIG_PREAMBLE: trig_hit = rx_evt.preamble_found_event;
      rsrc_pkg::TRIG_BOTH: trig_hit = rx_evt.strength_irq || rx_evt.preamble_found_event;
      default: trig_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_corr_done = corr_done;
    next_baseline = baseline;
    next_restart = 1'b0;
    next_gain_start = 1'b0;
    next_freq_start = 1'b0;
    tmr_load = 1'b0;
    tmr_val = 12'h000;
    case (state)
      rsrc_pkg::RX_OFF: begin
        if (rx_mode) begin
          next_state = rsrc_pkg::RX_FETCH;
          next_corr_done = 1'b0;
        end
      end
      rsrc_pkg::RX_FETCH: begin
        tmr_load = 1'b1;
        tmr_val = rom_q;
        next_state = rsrc_pkg::RX_STARTUP;
      end
      rsrc_pkg::RX_LOCK: begin
        if (expired) begin
          next_state = rsrc_pkg::RX_FETCH;
        end
      end
      rsrc_pkg::RX_STARTUP: begin
        if (expired) begin
          tmr_load = 1'b1;
          tmr_val = (rom_q >> rsrc_pkg::STRENGTH_DELAY_SHIFT)
                    << cfg.strength_smoothing_option;
          next_state = rsrc_pkg::RX_SAMPLE;
        end
      end
      rsrc_pkg::RX_SAMPLE: begin
        if (expired) begin
          next_state = rsrc_pkg::RX_READY;
          next_baseline = rx_evt.strength_value;
        end
      end
      rsrc_pkg::RX_READY: begin
        if (rx_evt.strength_update) begin
          next_baseline = rx_evt.strength_value;
        end
        if (!corr_done && trig_hit) begin
          next_gain_start = cfg.auto_gain_control_enable;
          next_freq_start = cfg.auto_freq_correction_enable;
          next_corr_done = 1'b1;
        end
        if (rx_evt.payload_complete_event
            && cfg.auto_restart_select != rsrc_pkg::AUTO_OFF) begin
          next_state = rsrc_pkg::RX_WAIT_FIFO;
        end else if (collision) begin
          next_state = rsrc_pkg::RX_FETCH;
          next_restart = 1'b1;
          next_corr_done = 1'b0;
        end
      end
      rsrc_pkg::RX_WAIT_FIFO: begin
        if (rx_evt.fifo_empty) begin
          tmr_load = 1'b1;
          tmr_val = {4'h0, cfg.inter_packet_wait};
          if (cfg.auto_restart_select == rsrc_pkg::AUTO_NEWFREQ) begin
            tmr_val = {4'h0, cfg.inter_packet_wait} + rsrc_pkg::RELOCK_EXTRA_US;
          end
          next_state = rsrc_pkg::RX_INTERPKT;
        end
      end
      rsrc_pkg::RX_INTERPKT: begin
        if (expired) begin
          next_state = rsrc_pkg::RX_FETCH;
          next_restart = 1'b1;
          next_corr_done = 1'b0;
        end
      end
      default: next_state = rsrc_pkg::RX_OFF;
    endcase
    if (user_restart) begin
      next_restart = 1'b1;
      next_corr_done = 1'b0;
      next_gain_start = 1'b0;
      next_freq_start = 1'b0;
      tmr_load = 1'b0;
      next_state = rsrc_pkg::RX_FETCH;
      if (cfg.restart_relock_trigger) begin
        tmr_load = 1'b1;
        tmr_val = rsrc_pkg::RELOCK_EXTRA_US;
        next_state = rsrc_pkg::RX_LOCK;
      end
    end
    if (!rx_mode) begin
      next_state = rsrc_pkg::RX_OFF;
      next_restart = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= rsrc_pkg::RX_OFF;
      corr_done <= 1'b0;
      baseline <= 8'h00;
      restart_pulse <= 1'b0;
      gain_start <= 1'b0;
      freq_start <= 1'b0;
    end else begin
      state <= next_state;
      corr_done <= next_corr_done;
      baseline <= next_baseline;
      restart_pulse <= next_restart;
      gain_start <= next_gain_start;
      freq_start <= next_freq_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs and read port
  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        rsrc_pkg::OFS_MODE: next_reg_rdata = {cfg.spread_family, 4'h0, cfg.op_mode};
        rsrc_pkg::OFS_RXCFG: next_reg_rdata = {cfg.collision_restart_enable,
          cfg.restart_no_relock_trigger, cfg.restart_relock_trigger,
          cfg.auto_freq_correction_enable, cfg.auto_gain_control_enable,
          cfg.correction_trigger_select};
        rsrc_pkg::OFS_LNA: next_reg_rdata = {cfg.amplifier_gain_select, 5'h00};
        rsrc_pkg::OFS_RECEIVE_BANDWIDTH: next_reg_rdata = {3'h0, cfg.receive_bandwidth};
        rsrc_pkg::OFS_AFCBW: next_reg_rdata = {3'h0, cfg.correction_bandwidth};
        rsrc_pkg::OFS_SYNC: next_reg_rdata = {cfg.auto_restart_select, 6'h00};
        rsrc_pkg::OFS_IPKT: next_reg_rdata = cfg.inter_packet_wait;
        rsrc_pkg::OFS_COLL: next_reg_rdata = cfg.collision_strength_threshold;
        rsrc_pkg::OFS_SMOOTH: next_reg_rdata = {6'h00, cfg.strength_smoothing_option};
        rsrc_pkg::OFS_STAT: next_reg_rdata = {3'h0, seq_init_sleep, sequencer_active,
          strength_sample_valid, receiver_ready, settled};
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      synth_enable <= 1'b0;
      receiver_enable <= 1'b0;
      receiver_ready <= 1'b0;
      strength_sample_valid <= 1'b0;
      lna_gain <= 3'h0;
    end else begin
      reg_rdata <= next_reg_rdata;
      synth_enable <= (cfg.op_mode >= rsrc_pkg::MODE_FSTX) && (cfg.op_mode <= rsrc_pkg::MODE_RX);
      receiver_enable <= rx_mode;
      receiver_ready <= (next_state >= rsrc_pkg::RX_SAMPLE);
      strength_sample_valid <= (next_state >= rsrc_pkg::RX_READY);
      lna_gain <= cfg.auto_gain_control_enable ? rx_evt.agc_gain
                                               : cfg.amplifier_gain_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  int st_cycles;
  logic [11:0] st_len;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_cycles <= 0;
      st_len <= 12'h000;
    end else begin
      st_cycles <= (state == rsrc_pkg::RX_STARTUP) ? st_cycles + 1 : 0;
      if (state == rsrc_pkg::RX_FETCH) st_len <= rom_q;
    end
  end

  startup_len_a: assert property ((state == rsrc_pkg::RX_STARTUP) && expired && rx_mode
    && !user_restart |-> st_cycles == int'(st_len) * rsrc_pkg::TICK_CYCLES)
    else $error("start-up delay length wrong");
  restart_gate_a: assert property ((cfg.restart_no_relock_trigger ||
    cfg.restart_relock_trigger) && !settled && !collision && state != rsrc_pkg::RX_INTERPKT
    |=> !restart_pulse) else $error("restart taken while not settled");
  trig_clear_a: assert property ($rose(cfg.restart_relock_trigger) && !reg_wr
    |=> !cfg.restart_relock_trigger) else $error("trigger bit did not clear");
  corr_once_a: assert property ((state == rsrc_pkg::RX_READY) && corr_done && !user_restart
    |=> !gain_start && !freq_start) else $error("second correction in a packet");
  trig_none_a: assert property ((cfg.correction_trigger_select == rsrc_pkg::TRIG_NONE)
    |=> !gain_start) else $error("correction without trigger");
  lna_manual_a: assert property (!cfg.auto_gain_control_enable
    |=> lna_gain == $past(cfg.amplifier_gain_select)) else $error("manual gain not used");
  auto_off_a: assert property ((state == rsrc_pkg::RX_READY) && rx_mode
    && (cfg.auto_restart_select == rsrc_pkg::AUTO_OFF) |=> state != rsrc_pkg::RX_WAIT_FIFO)
    else $error("auto restart while off");
  seq_stop_a: assert property (reg_wr && reg_addr == rsrc_pkg::OFS_SEQ
    && reg_wdata[rsrc_pkg::STOP_BIT] |=> !sequencer_active) else $error("stop ignored");
  seq_family_a: assert property (cfg.spread_family |=> !sequencer_active)
    else $error("sequencer on in spread family");
  rx_mode_a: assert property (rx_mode |=> receiver_enable && synth_enable)
    else $error("receive mode blocks off");
  collision_a: assert property ((state == rsrc_pkg::RX_READY) && collision && rx_mode
    && !rx_evt.payload_complete_event |=> restart_pulse ##1 !receiver_ready)
    else $error("collision did not restart");
  ready_cov_c: cover property ((state == rsrc_pkg::RX_SAMPLE) ##1 strength_sample_valid);
  auto_cov_c: cover property ((state == rsrc_pkg::RX_INTERPKT) ##1 restart_pulse);
  seq_cov_c: cover property ($rose(sequencer_active));
endmodule
`default_nettype wire

// ===== tb/rsrc_chain_model.sv
// receive chain stand-in raising events toward the control block
`timescale 1ns/10ps
`default_nettype none
module rsrc_chain_model (
  // clock
  input wire logic clk_sys,
  // events toward the control block
  output var rsrc_pkg::rsrc_evt_s evt
);
  initial evt = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle event: 0 strength irq, 1 preamble, 2 payload, 3 strength update
  // gain moves on every event so a stuck gain path shows up
  task automatic pulse(input int kind, input logic [7:0] v);
    @(posedge clk_sys);
    evt.agc_gain <= 3'($urandom);
    evt.strength_value <= v;
    evt.strength_irq <= (kind == 0);
    evt.preamble_found_event <= (kind == 1);
    evt.payload_complete_event <= (kind == 2);
    evt.strength_update <= (kind == 3);
    @(posedge clk_sys);
    evt.strength_irq <= 1'b0;
    evt.preamble_found_event <= 1'b0;
    evt.payload_complete_event <= 1'b0;
    evt.strength_update <= 1'b0;
  endtask
  // fifo level as the host leaves it after reading
  task automatic fifo(input logic e);
    @(posedge clk_sys);
    evt.fifo_empty <= e;
  endtask
endmodule
`default_nettype wire

// ===== tb/rsrc_ctrl_tb.sv
// self-checking bench for receiver start-up and restart control
`timescale 1ns/10ps
`default_nettype none
module rsrc_ctrl_tb;
  logic clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  rsrc_pkg::rsrc_evt_s rx_evt;
  logic synth_enable, receiver_enable, receiver_ready, strength_sample_valid;
  logic gain_start, freq_start, restart_pulse, sequencer_active;
  logic [2:0] lna_gain, g;
  int failures = 0, n_compared = 0, n_rst = 0, n_gain = 0, n_freq = 0, n;
  always #2 clk_sys = ~clk_sys;
  rsrc_ctrl rsrc_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_evt(rx_evt), .synth_enable(synth_enable), .receiver_enable(receiver_enable),
    .receiver_ready(receiver_ready), .strength_sample_valid(strength_sample_valid),
    .gain_start(gain_start), .freq_start(freq_start), .lna_gain(lna_gain),
    .restart_pulse(restart_pulse), .sequencer_active(sequencer_active));
  rsrc_chain_model rsrc_chain_model_inst (.clk_sys(clk_sys), .evt(rx_evt));
  always @(posedge clk_sys) begin
    n_rst <= n_rst + (restart_pulse === 1'b1);
    n_gain <= n_gain + (gain_start === 1'b1);
    n_freq <= n_freq + (freq_start === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
    n_compared++;
    if (v !== e) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", s, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // level wait, 0 ready 1 strength sample 2 restart; 5 percent tolerance plus pipeline slack
  task automatic wt(input int sel, input int cyc);
    n = 0;
    while ((sel == 2 ? restart_pulse : sel ? strength_sample_valid : receiver_ready) !== 1'b1
           && n < 40000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("delay ok", 16'h0001, 16'(n > cyc * 95 / 100 && n < cyc * 105 / 100 + 20));
  endtask
  task automatic results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    failures++;
    results;
  end
  initial begin
    void'($urandom(82));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'h09, 8'h01);
    rd(8'hFF, 8'h00);
    wr(8'h08, 8'h80);
    settle;
    chk("seq launch", 16'h0001, 16'(sequencer_active));
    wr(8'h08, 8'h40);
    settle;
    chk("seq stop", 16'h0000, 16'(sequencer_active));
    wr(8'h00, 8'h81);
    wr(8'h08, 8'h80);
    settle;
    chk("seq spread", 16'h0000, 16'(sequencer_active));
    $display("test sequencer done");
    g = 3'($urandom);
    wr(8'h00, 8'h01);
    wr(8'h02, {g, 5'h00});
    wr(8'h01, 8'h01);
    rsrc_chain_model_inst.pulse(0, 8'h00);
    settle;
    chk("manual gain", 16'(g), 16'(lna_gain));
    wr(8'h01, 8'h09);
    settle;
    chk("auto gain", 16'(rx_evt.agc_gain), 16'(lna_gain));
    $display("test gain done");
    // start at the widest bandwidth; a restart sent mid start-up must be dropped
    wr(8'h03, 8'h14);
    wr(8'h00, 8'h05);
    wr(8'h01, 8'h49);
    chk("rx on", 16'h0003, {14'h0000, synth_enable, receiver_enable});
    wt(0, 63 * 250);
    chk("dropped restart", 16'h0000, 16'(n_rst));
    wt(1, ((63 >> 3) << 2) * 250);
    rsrc_chain_model_inst.pulse(0, 8'h00);
    rsrc_chain_model_inst.pulse(0, 8'h00);
    settle;
    chk("corr count", 16'h0100, {n_gain[7:0], n_freq[7:0]});
    wr(8'h0A, 8'h00);
    wr(8'h01, 8'h4E);
    settle;
    chk("user restart", 16'h0001, 16'(n_rst));
    wt(0, 63 * 250);
    wt(1, (63 >> 3) * 250);
    rsrc_chain_model_inst.pulse(0, 8'h00);
    settle;
    chk("irq ignored", 16'h0001, 16'(n_gain));
    rsrc_chain_model_inst.pulse(1, 8'h00);
    settle;
    chk("preamble", 16'h0002, 16'(n_gain));
    $display("test restart done");
    wr(8'h07, 8'h0A);
    wr(8'h01, 8'h8E);
    rsrc_chain_model_inst.pulse(3, 8'h05);
    rsrc_chain_model_inst.pulse(3, 8'h0A);
    settle;
    chk("small rise", 16'h0001, 16'(n_rst));
    rsrc_chain_model_inst.pulse(3, 8'h1A);
    settle;
    chk("collision", 16'h0002, 16'(n_rst));
    $display("test collision done");
    // narrow receive bandwidth would take far longer; correction bandwidth must win
    wr(8'h00, 8'h01);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h11);
    wr(8'h01, 8'h1E);
    wr(8'h00, 8'h05);
    wt(0, 71 * 250);
    wt(1, (71 >> 3) * 250);
    rsrc_chain_model_inst.pulse(1, 8'h00);
    settle;
    chk("freq corr", 16'h0001, 16'(n_freq));
    $display("test correction bandwidth done");
    // relock restart with correction on: lock wait first, then the widest bandwidth start-up
    wr(8'h04, 8'h14);
    wr(8'h01, 8'h3F);
    settle;
    chk("relock restart", 16'h0003, 16'(n_rst));
    wt(0, (60 + 63) * 250);
    wt(1, (63 >> 3) * 250);
    rsrc_chain_model_inst.pulse(0, 8'h00);
    settle;
    chk("both trig", 16'h0402, {n_gain[7:0], n_freq[7:0]});
    $display("test relock done");
    wr(8'h06, 8'h01);
    wr(8'h05, 8'h00);
    rsrc_chain_model_inst.fifo(1'b1);
    rsrc_chain_model_inst.pulse(2, 8'h00);
    repeat (300) @(posedge clk_sys);
    #1 chk("auto off", 16'h0003, 16'(n_rst));
    wr(8'h05, 8'h40);
    rsrc_chain_model_inst.fifo(1'b0);
    rsrc_chain_model_inst.pulse(2, 8'h00);
    repeat (300) @(posedge clk_sys);
    #1 chk("fifo wait", 16'h0003, 16'(n_rst));
    rsrc_chain_model_inst.fifo(1'b1);
    wt(2, 250);
    settle;
    chk("auto restart", 16'h0004, 16'(n_rst));
    $display("test auto restart done");
    results;
  end
endmodule
`default_nettype wire
